// >>> ssc_pkg.sv
// Package: constants for the synthesizer serial configuration control
package ssc_pkg;
   // Word layout, first bit shifted is the test field msb
   localparam int TEST_W      = 2;
   localparam int ODIV_W      = 2;
   localparam int FDIV_W      = 9;
   localparam int WORD_W      = TEST_W + ODIV_W + FDIV_W;
   localparam int FDIV_LSB    = 0;
   localparam int ODIV_LSB    = FDIV_W;
   localparam int TEST_LSB    = FDIV_W + ODIV_W;
   localparam logic [FDIV_W-1:0] FDIV_RST = 9'h0C8;
   localparam logic [ODIV_W-1:0] ODIV_RST = 2'h0;
   localparam logic [TEST_W-1:0] TEST_RST = 2'h0;
   localparam int DCNT_W      = 10;
   // Mode states, one-hot
   typedef enum logic [1:0] {
      SSC_PAR = 2'h1,
      SSC_SER = 2'h2
   } ssc_mode_type;
endpackage

// >>> ssc_edge_if.sv
// Interface: synchronous edge detector signals
`timescale 1ns/1ns
interface ssc_edge_if;
   logic level;
   logic rise;
   modport det (input level, output rise);
   modport use_side (output level, input rise);
endinterface

// >>> ssc_edge_det.sv
// Rising edge detector for a pin sampled on clk
`timescale 1ns/1ns
module ssc_edge_det (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic ce,
   ssc_edge_if.det   e
);
   logic prev_ff;
   logic nxt_prev;

   always_comb begin
      nxt_prev = e.level;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev_ff <= 1'b0;
      end else if (ce) begin
         prev_ff <= nxt_prev;
      end
   end

   assign e.rise = ce & e.level & ~prev_ff;
endmodule

// >>> ssc_ctrl.sv
// Serial configuration, divider reset and reference select control
`timescale 1ns/1ns
// Notes on behaviour
// - Divider reset high clears dividers, true clocks low, inverted high.
// - Divider reset low lets dividers run and enables both outputs.
// - Divider reset keeps loaded feedback, output and test values.
// - Each rising serial clock edge shifts the serial data bit in.
// - Only serial clock advances shift register; bits wait for transfer.
// - Transfer strobe copies shift register into the dividers.
// - Select high uses crystal reference, low uses single-ended input.
// - Test output active in serial mode, low in parallel mode.
module ssc_ctrl #(
   parameter int FDIV_W = ssc_pkg::FDIV_W
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              ce,
   input  wire logic              divider_reset_input,
   input  wire logic              reference_source_select,
   input  wire logic              serial_clock,
   input  wire logic              serial_data,
   input  wire logic              transfer_strobe,
   input  wire logic              xtal_ref,
   input  wire logic              single_ref,
   input  wire logic              vco_clk_tick,
   output logic                   true_clock_outputs,
   output logic                   inverted_clock_outputs,
   output logic                   pll_reference,
   output logic                   test_output,
   output logic [FDIV_W-1:0]      fdiv_value,
   output logic [ssc_pkg::ODIV_W-1:0] odiv_value,
   output logic [ssc_pkg::TEST_W-1:0] test_value
);
   // ----------------------------------------
   // Edge detection of serial clock and strobe
   // ----------------------------------------
   ssc_edge_if sck_e ();
   ssc_edge_if ld_e ();
   assign sck_e.level = serial_clock;
   assign ld_e.level  = transfer_strobe;

   ssc_edge_det u_sck (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .e       (sck_e)
   );
   ssc_edge_det u_ld (
      .clk     (clk),
      .sys_rst (sys_rst),
      .ce      (ce),
      .e       (ld_e)
   );

   // ----------------------------------------
   // Shift register, loaded values and mode
   // ----------------------------------------
   logic [ssc_pkg::WORD_W-1:0]  shift_ff, nxt_shift;
   logic [FDIV_W-1:0]           fdiv_ff, nxt_fdiv;
   logic [ssc_pkg::ODIV_W-1:0]  odiv_ff, nxt_odiv;
   logic [ssc_pkg::TEST_W-1:0]  test_ff, nxt_test;
   ssc_pkg::ssc_mode_type       mode_ff, nxt_mode;

   always_comb begin
      nxt_shift = shift_ff;
      nxt_fdiv  = fdiv_ff;
      nxt_odiv  = odiv_ff;
      nxt_test  = test_ff;
      nxt_mode  = mode_ff;
      // Only a serial clock edge moves the shift register
      if (sck_e.rise) begin
         nxt_shift = {shift_ff[ssc_pkg::WORD_W-2:0], serial_data};
         nxt_mode  = ssc_pkg::SSC_SER;
      end
      // Divider reset does not touch these, so values survive it
      if (ld_e.rise) begin
         nxt_fdiv = shift_ff[ssc_pkg::FDIV_LSB +: FDIV_W];
         nxt_odiv = shift_ff[ssc_pkg::ODIV_LSB +: ssc_pkg::ODIV_W];
         nxt_test = shift_ff[ssc_pkg::TEST_LSB +: ssc_pkg::TEST_W];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shift_ff <= '0;
         fdiv_ff  <= ssc_pkg::FDIV_RST;
         odiv_ff  <= ssc_pkg::ODIV_RST;
         test_ff  <= ssc_pkg::TEST_RST;
         mode_ff  <= ssc_pkg::SSC_PAR;
      end else if (ce) begin
         shift_ff <= nxt_shift;
         fdiv_ff  <= nxt_fdiv;
         odiv_ff  <= nxt_odiv;
         test_ff  <= nxt_test;
         mode_ff  <= nxt_mode;
      end
   end

   // ----------------------------------------
   // Output divider and clock outputs
   // ----------------------------------------
   // Toggles every 2^odiv vco ticks, so divides by 2^(odiv+1); phase only, no analog
   logic [ssc_pkg::DCNT_W-1:0] dcnt_ff, nxt_dcnt;
   logic                       clk_ff, nxt_clk;
   logic [ssc_pkg::DCNT_W-1:0] half_lim;

   always_comb begin
      half_lim = ssc_pkg::DCNT_W'(1) << odiv_ff;
      nxt_dcnt = dcnt_ff;
      nxt_clk  = clk_ff;
      if (divider_reset_input) begin
         nxt_dcnt = '0;
         nxt_clk  = 1'b0;
      end else if (vco_clk_tick) begin
         // Dividers run once reset is low
         if (dcnt_ff + ssc_pkg::DCNT_W'(1) >= half_lim) begin
            nxt_dcnt = '0;
            nxt_clk  = ~clk_ff;
         end else begin
            nxt_dcnt = dcnt_ff + ssc_pkg::DCNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dcnt_ff                <= '0;
         clk_ff                 <= 1'b0;
         true_clock_outputs     <= 1'b0;
         inverted_clock_outputs <= 1'b1;
         pll_reference          <= 1'b0;
         test_output            <= 1'b0;
      end else if (ce) begin
         dcnt_ff                <= nxt_dcnt;
         clk_ff                 <= nxt_clk;
         true_clock_outputs     <= nxt_clk;
         inverted_clock_outputs <= ~nxt_clk;
         // Crystal when select high, single-ended otherwise
         pll_reference <= reference_source_select ? xtal_ref : single_ref;
         // Parallel mode keeps it low; serial shows test field lsb
         test_output <= (nxt_mode == ssc_pkg::SSC_SER) ? nxt_test[0] : 1'b0;
      end
   end

   assign fdiv_value = fdiv_ff;
   assign odiv_value = odiv_ff;
   assign test_value = test_ff;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_rst_out;
      @(posedge clk) disable iff (sys_rst)
      (ce && divider_reset_input) |=>
         (!true_clock_outputs && inverted_clock_outputs);
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("reset outputs");

   property p_compl;
      @(posedge clk) disable iff (sys_rst)
      $past(ce) && !$past(divider_reset_input) |->
         (true_clock_outputs != inverted_clock_outputs);
   endproperty
   a_compl: assert property (p_compl) else $error("outputs not paired");

   property p_keep;
      @(posedge clk) disable iff (sys_rst)
      (divider_reset_input && !ld_e.rise) |=> $stable(fdiv_ff);
   endproperty
   a_keep: assert property (p_keep) else $error("value lost");

   property p_shift;
      @(posedge clk) disable iff (sys_rst)
      sck_e.rise |=> shift_ff[0] == $past(serial_data);
   endproperty
   a_shift: assert property (p_shift) else $error("bit not shifted");

   property p_hold;
      @(posedge clk) disable iff (sys_rst)
      !sck_e.rise |=> $stable(shift_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("shift moved");

   property p_load;
      @(posedge clk) disable iff (sys_rst)
      ld_e.rise |=> fdiv_ff == $past(shift_ff[FDIV_W-1:0]);
   endproperty
   a_load: assert property (p_load) else $error("load failed");

   property p_ref;
      @(posedge clk) disable iff (sys_rst)
      (ce && reference_source_select) |=> pll_reference == $past(xtal_ref);
   endproperty
   a_ref: assert property (p_ref) else $error("wrong reference");

   property p_par;
      @(posedge clk) disable iff (sys_rst)
      (mode_ff == ssc_pkg::SSC_PAR) |-> !test_output;
   endproperty
   a_par: assert property (p_par) else $error("test not low");

   property p_ser;
      @(posedge clk) disable iff (sys_rst)
      (mode_ff == ssc_pkg::SSC_SER) |-> test_output == test_ff[0];
   endproperty
   a_ser: assert property (p_ser) else $error("test not shown");

   property p_dcnt;
      @(posedge clk) disable iff (sys_rst)
      (ce && divider_reset_input) |=> dcnt_ff == '0;
   endproperty
   a_dcnt: assert property (p_dcnt) else $error("divider not reset");

   // Clock enable low must freeze every register, shift register included
   property p_frz;
      @(posedge clk) disable iff (sys_rst)
      !ce |=> $stable(shift_ff) && $stable(fdiv_ff) &&
         $stable(true_clock_outputs);
   endproperty
   a_frz: assert property (p_frz) else $error("frozen state moved");

   c_shift: cover property (@(posedge clk) sck_e.rise);
   c_load:  cover property (@(posedge clk) ld_e.rise);
   c_rst:   cover property (@(posedge clk) divider_reset_input ##1
                            !divider_reset_input);
   c_ser:   cover property (@(posedge clk) mode_ff == ssc_pkg::SSC_SER ##1
                            test_output);
endmodule

// >>> ssc_host.sv
// Host controller model driving the serial programming lines
`timescale 1ns/1ns
module ssc_host (
   input  wire logic clk,
   output logic      serial_clock,
   output logic      serial_data,
   output logic      transfer_strobe
);
   initial begin
      serial_clock    = 1'h0;
      serial_data     = 1'h0;
      transfer_strobe = 1'h0;
   end
   // Three cycles a level, so a clk-sampled edge is never missed
   task automatic hold3();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic shift(input logic [ssc_pkg::WORD_W-1:0] w);
      for (int i = ssc_pkg::WORD_W - 1; i >= 0; i--) begin
         serial_data = w[i];
         hold3();
         serial_clock = 1'h1;
         hold3();
         serial_clock = 1'h0;
      end
      serial_data = 1'h0; // Driven low once the word is shifted
   endtask
   task automatic load();
      transfer_strobe = 1'h1;
      hold3();
      transfer_strobe = 1'h0;
      hold3();
   endtask
endmodule

// >>> synth_serial_config_control_bench.sv
// Self-checking testbench for the serial configuration control
`timescale 1ns/1ns
module synth_serial_config_control_bench;
   logic       clk, sys_rst, ce, drst, rsel, xref, sref, tick;
   logic       sck, sda, stb, tco, ico, pref, tout;
   logic [8:0] fdiv;
   logic [1:0] odiv, tval;
   int         num_errors = 0;
   int         check_count = 0;
   localparam logic [12:0] WORD = {2'h1, 2'h2, 9'h15A};
   ssc_host ssc_host_i (.clk(clk), .serial_clock(sck), .serial_data(sda),
      .transfer_strobe(stb));
   ssc_ctrl ssc_ctrl_i (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .divider_reset_input(drst), .reference_source_select(rsel),
      .serial_clock(sck), .serial_data(sda), .transfer_strobe(stb),
      .xtal_ref(xref), .single_ref(sref), .vco_clk_tick(tick),
      .true_clock_outputs(tco), .inverted_clock_outputs(ico),
      .pll_reference(pref), .test_output(tout), .fdiv_value(fdiv),
      .odiv_value(odiv), .test_value(tval));
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
      check_count++;
      if (s !== e) begin
         $display("Error %s expected %h seen %h", n, e, s);
         num_errors++;
      end
   endtask
   task automatic results();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk("fdiv", ssc_pkg::FDIV_RST, fdiv);
      chk("odiv", 9'(ssc_pkg::ODIV_RST), 9'(odiv));
      chk("true", 9'h000, 9'(tco));
      chk("inv", 9'h001, 9'(ico));
      chk("test_out", 9'h000, 9'(tout));
   endtask
   task automatic t_load();
      ssc_host_i.shift(WORD);
      chk("fdiv held", ssc_pkg::FDIV_RST, fdiv);
      ssc_host_i.load();
      chk("fdiv", 9'h15A, fdiv);
      chk("odiv", 9'h002, 9'(odiv));
      chk("test", 9'h001, 9'(tval));
      chk("test_out", 9'h001, 9'(tout));
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         tick = 1'h1;
         cyc(1);
         tick = 1'h0;
         cyc(1);
      end
   endtask
   task automatic t_mreset();
      drst = 1'h1;
      pulse(6);
      chk("true", 9'h000, 9'(tco));
      chk("inv", 9'h001, 9'(ico));
      chk("fdiv", 9'h15A, fdiv);
      chk("odiv", 9'h002, 9'(odiv));
      drst = 1'h0;
      pulse(5);
      chk("true run", 9'h001, 9'(tco));
      chk("inv run", 9'h000, 9'(ico));
   endtask
   task automatic t_freeze();
      ce = 1'h0;
      drst = 1'h1;
      ssc_host_i.shift(~WORD);
      chk("true frozen", 9'h001, 9'(tco));
      ce = 1'h1;
      cyc(1);
      chk("true", 9'h000, 9'(tco));
      drst = 1'h0;
      ssc_host_i.load();
      chk("fdiv frozen", 9'h15A, fdiv);
   endtask
   task automatic t_ref();
      for (int s = 0; s < 2; s++) begin
         rsel = s[0];
         xref = s[0];
         sref = ~s[0];
         cyc(2);
         chk("ref", 9'h001, 9'(pref));
         xref = ~s[0];
         sref = s[0];
         cyc(2);
         chk("ref", 9'h000, 9'(pref));
      end
   endtask
   initial begin
      {sys_rst, ce, rsel} = 3'h7;
      {drst, xref, sref, tick} = 4'h0;
      cyc(8);
      sys_rst = 1'h0;
      cyc(1);
      t_reset();
      t_load();
      t_mreset();
      t_freeze();
      t_ref();
      results();
   end
   // Whole run needs about 10.4 us; the limit leaves a wide margin
   initial begin
      #2000000;
      num_errors++;
      results();
   end
endmodule
